// File: bench/pit_cpu_model.sv
`include "pit_params.svh"

module pit_cpu_model
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [`PIT_ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hang;
    // Byte strobes for the next transfers; whole word unless a test narrows it
    logic [3:0] lanes = 4'hF;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        hang = 1'b0;
    end
    // Strobes follow lanes, but reads return the whole word, so a count read is never torn
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= lanes;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        hang = hang | (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic set_lanes(input logic [3:0] l);
        lanes = l;
    endtask : set_lanes
endmodule : pit_cpu_model

// File: bench/pit_timer_checker.sv
`include "pit_params.svh"

module pit_timer_checker
    import pit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PIT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic doze_mode,
    input wire logic timeout_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_acc;
    logic ctl_wr;
    assign wr_acc = psel && penable && pwrite;
    assign ctl_wr = wr_acc && paddr == `PIT_OFF_CTRL && pstrb[0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_bad_addr;
        paddr != `PIT_OFF_CTRL && paddr != `PIT_OFF_MOD && paddr != `PIT_OFF_CNT;
    endsequence
    property p_ready;
        pready == (psel && penable);
    endproperty
    property p_cnt_wr;
        wr_acc && paddr == `PIT_OFF_CNT |-> !pslverr;
    endproperty
    property p_bad;
        s_setup ##0 s_bad_addr |=> pslverr && prdata == `PIT_READ_ZERO;
    endproperty
    property p_rd_hi;
        s_setup |=> prdata[31:16] == 16'h0000;
    endproperty
    property p_hold;
        $changed(prdata) || $changed(pslverr) |-> $past(psel && !penable);
    endproperty
    property p_flag_clr;
        ctl_wr && pwdata[`PIT_BIT_FLAG] |-> ##[1:2] !timeout_irq;
    endproperty
    property p_allow;
        ctl_wr && !pwdata[`PIT_BIT_IRQ_ALLOW] |-> ##2 !timeout_irq;
    endproperty
    // The request only drops through a register write
    property p_fall;
        $fell(timeout_irq) |-> $past(wr_acc) || $past(wr_acc, 2);
    endproperty
    a_ready: assert property (p_ready) else $error("pready wrong");
    a_cnt_wr: assert property (p_cnt_wr) else $error("count write errored");
    a_bad: assert property (p_bad) else $error("unmapped access not refused");
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
    a_allow: assert property (p_allow) else $error("masked request high");
    a_fall: assert property (p_fall) else $error("request fell alone");
endmodule : pit_timer_checker

bind pit_timer pit_timer_checker i_chk
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .doze_mode(doze_mode), .timeout_irq(timeout_irq)
);

// File: bench/tb_periodic_interval_timer.sv
`include "pit_params.svh"

module tb_periodic_interval_timer
    import pit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, doze_mode, psel, penable, pwrite, pready, pslverr, timeout_irq, err;
    logic [`PIT_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, snap, cfg;
    logic [3:0] pstrb;
    int mismatches, n_compared, seed, t1, i;
    int cyc = 0;
    pit_count_type m;
    pit_div_type sel;

    pit_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .doze_mode(doze_mode), .timeout_irq(timeout_irq));
    pit_cpu_model i_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;

    task automatic complete_run();
        // A bus transfer that never saw pready counts against the run
        if (i_cpu.hang)
        begin
            mismatches++;
        end
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_cpu.xfer(1'b1, a, d, rd, err);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string msg);
        i_cpu.xfer(1'b0, a, 32'h0, rd, err);
        check(rd, exp, msg);
    endtask : rd_chk
    // Sample at the edge wake-up so the value is the settled pre-edge one
    task automatic wait_irq();
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (timeout_irq !== 1'b1 && n < 4000);
        if (n >= 4000 || i_cpu.hang)
        begin
            mismatches++;
            complete_run();
        end
    endtask : wait_irq

    initial
    begin
        seed = 32'h496c65cd;
        mismatches = 0;
        n_compared = 0;
        presetn = 1'b0;
        doze_mode = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(`PIT_OFF_CTRL, 32'h0, "ctrl reset");
        rd_chk(`PIT_OFF_MOD, 32'h0000FFFF, "mod reset");
        wr(`PIT_OFF_CNT, 32'h1234);
        check(32'(err), 32'h0, "count write error");
        rd_chk(`PIT_OFF_CNT, 32'h0000FFFF, "count write kept");
        rd_chk(12'h00C, 32'h0, "unmapped read");
        check(32'(err), 32'h1, "unmapped error");
        $display("test registers done");
        for (i = 0; i < 3; i++)
        begin
            m = 16'(4 + ($random(seed) & 7));
            sel = (i == 0) ? 4'h0 : 4'($random(seed) & 3);
            cfg = 32'h0000_001A | (32'(sel) << 8);
            wr(`PIT_OFF_CTRL, cfg);
            wr(`PIT_OFF_MOD, 32'(m));
            rd_chk(`PIT_OFF_CNT, 32'(m), "immediate load");
            rd_chk(`PIT_OFF_MOD, 32'(m), "modulus readback");
            wr(`PIT_OFF_CTRL, cfg | 32'h1);
            wait_irq();
            t1 = cyc;
            wr(`PIT_OFF_CTRL, cfg | 32'h5);
            wait_irq();
            check(32'(cyc - t1), (32'h1 << sel) * (32'(m) + 1), "period");
            wr(`PIT_OFF_CTRL, cfg | 32'h4);
        end
        $display("test reload done");
        wr(`PIT_OFF_CTRL, 32'h18);
        wr(`PIT_OFF_MOD, 32'h2);
        wr(`PIT_OFF_CTRL, 32'h19);
        wait_irq();
        check(32'(timeout_irq), 32'h1, "free-run flag");
        i_cpu.xfer(1'b0, `PIT_OFF_CNT, 32'h0, rd, err);
        check(32'(rd[15:8]), 32'hFF, "wrapped count");
        wr(`PIT_OFF_CTRL, 32'h11);
        @(posedge pclk);
        check(32'(timeout_irq), 32'h0, "masked request");
        i_cpu.xfer(1'b0, `PIT_OFF_CTRL, 32'h0, rd, err);
        check(32'(rd[`PIT_BIT_FLAG]), 32'h1, "flag kept");
        wr(`PIT_OFF_MOD, 32'h0100);
        i_cpu.xfer(1'b0, `PIT_OFF_CTRL, 32'h0, rd, err);
        check(32'(rd[`PIT_BIT_FLAG]), 32'h0, "modulus write clears");
        $display("test free-run done");
        wr(`PIT_OFF_CTRL, 32'h51);
        doze_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        i_cpu.xfer(1'b0, `PIT_OFF_CNT, 32'h0, snap, err);
        repeat (8) @(posedge pclk);
        rd_chk(`PIT_OFF_CNT, snap, "doze freeze");
        doze_mode <= 1'b0;
        repeat (4) @(posedge pclk);
        i_cpu.xfer(1'b0, `PIT_OFF_CNT, 32'h0, rd, err);
        check(32'(rd < snap), 32'h1, "doze resume");
        wr(`PIT_OFF_CTRL, 32'h10);
        i_cpu.xfer(1'b0, `PIT_OFF_CNT, 32'h0, snap, err);
        repeat (8) @(posedge pclk);
        rd_chk(`PIT_OFF_CNT, snap, "stopped hold");
        wr(`PIT_OFF_CTRL, 32'h0A);
        wr(`PIT_OFF_MOD, 32'h0003);
        rd_chk(`PIT_OFF_CNT, snap, "no immediate load");
        wr(`PIT_OFF_CTRL, 32'h0B);
        wait_irq();
        // Divide by one, so the reload has landed by the setup edge
        rd_chk(`PIT_OFF_CNT, 32'h0000_0003, "reload from latch");
        wr(`PIT_OFF_CTRL, 32'h04);
        i_cpu.set_lanes(4'h2);
        wr(`PIT_OFF_MOD, 32'h0000_ABCD);
        i_cpu.set_lanes(4'hF);
        rd_chk(`PIT_OFF_MOD, 32'h0000_AB03, "byte lane merge");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(`PIT_OFF_CNT, 32'h0000FFFF, "second reset");
        $display("test doze, latch and reset done");
        complete_run();
    end
endmodule : tb_periodic_interval_timer

// File: core/pit_prescaler.sv
`include "pit_params.svh"

module pit_prescaler
    import pit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic restart,
    input wire pit_div_type divider_select,
    output logic tick
);

    pit_count_type presc;
    pit_count_type next_presc;

    // Tick on the 2^select-th running cycle after a restart
    assign tick = run && ((presc & pit_div_mask(divider_select)) == `PIT_COUNT_ZERO);

    always_comb
    begin
        next_presc = presc;
        if (restart)
        begin
            next_presc = `PIT_PRESC_RESET;
        end
        else if (run)
        begin
            next_presc = presc - `PIT_COUNT_ONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc <= `PIT_PRESC_RESET;
        end
        else
        begin
            presc <= next_presc;
        end
    end

endmodule : pit_prescaler

// File: core/pit_timer.sv
`include "pit_params.svh"

module pit_timer
    import pit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PIT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic doze_mode,
    output logic timeout_irq
);

    function automatic pit_sel_type pit_decode(input logic [`PIT_ADDR_W-1:0] addr);
        unique case (addr)
            `PIT_OFF_CTRL: pit_decode = PIT_SEL_CTRL;
            `PIT_OFF_MOD: pit_decode = PIT_SEL_MOD;
            `PIT_OFF_CNT: pit_decode = PIT_SEL_CNT;
            default: pit_decode = PIT_SEL_NONE;
        endcase
    endfunction : pit_decode

    // Byte lanes 0 and 1 only; the upper half of the word is not stored
    function automatic pit_count_type pit_merge(input pit_count_type old,
        input logic [15:0] data, input logic [1:0] strb);
        pit_merge = old;
        if (strb[0])
        begin
            pit_merge[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            pit_merge[15:8] = data[15:8];
        end
    endfunction : pit_merge

    logic run;
    logic reload_select;
    logic timeout_flag;
    logic timeout_irq_allow;
    logic immediate_load;
    logic doze_stop;
    pit_div_type divider_select;
    pit_count_type counter_value;
    pit_count_type modulus_value;
    logic doze_meta;
    logic doze_sync;

    logic next_run;
    logic next_reload_select;
    logic next_timeout_flag;
    logic next_timeout_irq_allow;
    logic next_immediate_load;
    logic next_doze_stop;
    pit_div_type next_divider_select;
    pit_count_type next_counter_value;
    pit_count_type next_modulus_value;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic next_timeout_irq;

    pit_sel_type sel;
    logic setup_phase;
    logic access_phase;
    logic wr_ctrl;
    logic wr_mod;
    logic load_now;
    logic reload_now;
    logic counting;
    logic tick;
    pit_count_type ctrl_view;
    pit_count_type ctrl_new;
    pit_count_type mod_new;

    assign sel = pit_decode(paddr);
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    // Zero wait states: every access completes in its first access cycle
    assign pready = access_phase;
    // Writes to the count register decode but change nothing
    assign wr_ctrl = access_phase && pwrite && (sel == PIT_SEL_CTRL);
    assign wr_mod = access_phase && pwrite && (sel == PIT_SEL_MOD);

    always_comb
    begin
        ctrl_view = `PIT_COUNT_ZERO;
        ctrl_view[`PIT_BIT_RUN] = run;
        ctrl_view[`PIT_BIT_RELOAD] = reload_select;
        ctrl_view[`PIT_BIT_FLAG] = timeout_flag;
        ctrl_view[`PIT_BIT_IRQ_ALLOW] = timeout_irq_allow;
        ctrl_view[`PIT_BIT_IMM_LOAD] = immediate_load;
        ctrl_view[`PIT_BIT_DOZE_STOP] = doze_stop;
        ctrl_view[`PIT_DIV_MSB:`PIT_DIV_LSB] = divider_select;
    end

    assign ctrl_new = pit_merge(ctrl_view, pwdata[15:0], pstrb[1:0]);
    assign mod_new = pit_merge(modulus_value, pwdata[15:0], pstrb[1:0]);

    // Frozen while disabled, or in doze with doze stopping chosen
    assign counting = run && !(doze_stop && doze_sync);
    assign load_now = wr_mod && immediate_load;
    assign reload_now = tick && (counter_value == `PIT_COUNT_ZERO);

    pit_prescaler u_prescaler
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(counting),
        .restart(load_now || reload_now),
        .divider_select(divider_select),
        .tick(tick)
    );

    always_comb
    begin
        next_run = run;
        next_reload_select = reload_select;
        next_timeout_irq_allow = timeout_irq_allow;
        next_immediate_load = immediate_load;
        next_doze_stop = doze_stop;
        next_divider_select = divider_select;
        next_modulus_value = modulus_value;
        next_counter_value = counter_value;
        next_timeout_flag = timeout_flag;

        if (wr_ctrl)
        begin
            next_run = ctrl_new[`PIT_BIT_RUN];
            next_reload_select = ctrl_new[`PIT_BIT_RELOAD];
            next_timeout_irq_allow = ctrl_new[`PIT_BIT_IRQ_ALLOW];
            next_immediate_load = ctrl_new[`PIT_BIT_IMM_LOAD];
            next_doze_stop = ctrl_new[`PIT_BIT_DOZE_STOP];
            next_divider_select = ctrl_new[`PIT_DIV_MSB:`PIT_DIV_LSB];
            // Write-one clears; writing zero leaves the flag alone
            if (pstrb[0] && pwdata[`PIT_BIT_FLAG])
            begin
                next_timeout_flag = 1'b0;
            end
        end

        if (wr_mod)
        begin
            next_modulus_value = mod_new;
            next_timeout_flag = 1'b0;
        end

        if (load_now)
        begin
            next_counter_value = mod_new;
        end
        else if (tick)
        begin
            if (counter_value == `PIT_COUNT_ZERO)
            begin
                if (reload_select)
                begin
                    next_counter_value = modulus_value;
                end
                else
                begin
                    next_counter_value = `PIT_WRAP_VALUE;
                end
            end
            else
            begin
                next_counter_value = counter_value - `PIT_COUNT_ONE;
                // Set beats a clear in the same cycle so no timeout is lost
                if (counter_value == `PIT_COUNT_ONE)
                begin
                    next_timeout_flag = 1'b1;
                end
            end
        end

        next_timeout_irq = next_timeout_flag && next_timeout_irq_allow;
    end

    // Read data is captured in the setup cycle, so one access sees one count
    always_comb
    begin
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup_phase)
        begin
            next_prdata = `PIT_READ_ZERO;
            next_pslverr = 1'b0;
            unique case (sel)
                PIT_SEL_CTRL: next_prdata[15:0] = ctrl_view;
                PIT_SEL_MOD: next_prdata[15:0] = modulus_value;
                PIT_SEL_CNT: next_prdata[15:0] = counter_value;
                PIT_SEL_NONE: next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run <= 1'b0;
            reload_select <= 1'b0;
            timeout_flag <= 1'b0;
            timeout_irq_allow <= 1'b0;
            immediate_load <= 1'b0;
            doze_stop <= 1'b0;
            divider_select <= `PIT_DIV_RESET;
            counter_value <= `PIT_COUNT_RESET;
            modulus_value <= `PIT_MOD_RESET;
            timeout_irq <= 1'b0;
            prdata <= `PIT_READ_ZERO;
            pslverr <= 1'b0;
        end
        else
        begin
            run <= next_run;
            reload_select <= next_reload_select;
            timeout_flag <= next_timeout_flag;
            timeout_irq_allow <= next_timeout_irq_allow;
            immediate_load <= next_immediate_load;
            doze_stop <= next_doze_stop;
            divider_select <= next_divider_select;
            counter_value <= next_counter_value;
            modulus_value <= next_modulus_value;
            timeout_irq <= next_timeout_irq;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Doze comes from the power controller, outside this clock's timing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            doze_meta <= 1'b0;
            doze_sync <= 1'b0;
        end
        else
        begin
            doze_meta <= doze_mode;
            doze_sync <= doze_meta;
        end
    end

endmodule : pit_timer

// File: shared/pit_params.svh
// Function
// - Count register read-only, writes complete normally
// - Reload mode loads modulus at zero
// - Free-run mode wraps zero to 0xFFFF
// - Timeout flag set when counter reaches zero
// - Interrupt only when flag and enable set
// - Immediate-load modulus write loads counter directly
// - Flag cleared by write-one or modulus write
// - Prescaler divides bus clock by 2^select
// - Sixteen-bit counter decrements through prescaler
// - Run bit clear holds counter and prescaler
// - Any counter load restarts prescaler at 0xFFFF
// - Modulus read returns latch, not counter
// - Doze stopping freezes timer, resumes afterwards
`ifndef PIT_PARAMS_SVH
`define PIT_PARAMS_SVH

`define PIT_ADDR_W 12
`define PIT_OFF_CTRL 12'h000
`define PIT_OFF_MOD 12'h004
`define PIT_OFF_CNT 12'h008

`define PIT_BIT_RUN 0
`define PIT_BIT_RELOAD 1
`define PIT_BIT_FLAG 2
`define PIT_BIT_IRQ_ALLOW 3
`define PIT_BIT_IMM_LOAD 4
`define PIT_BIT_DOZE_STOP 6
`define PIT_DIV_LSB 8
`define PIT_DIV_MSB 11

`define PIT_COUNT_RESET 16'hFFFF
`define PIT_MOD_RESET 16'hFFFF
`define PIT_PRESC_RESET 16'hFFFF
`define PIT_WRAP_VALUE 16'hFFFF
`define PIT_COUNT_ZERO 16'h0000
`define PIT_COUNT_ONE 16'h0001
`define PIT_DIV_RESET 4'h0
`define PIT_READ_ZERO 32'h0000_0000

`endif

// File: shared/pit_pkg.sv
package pit_pkg;

    typedef logic [15:0] pit_count_type;
    typedef logic [3:0] pit_div_type;

    typedef enum logic [3:0]
    {
        PIT_SEL_NONE = 4'b0001,
        PIT_SEL_CTRL = 4'b0010,
        PIT_SEL_MOD = 4'b0100,
        PIT_SEL_CNT = 4'b1000
    } pit_sel_type;

    // Low bits that must all be zero for a prescaler period to end
    function automatic pit_count_type pit_div_mask(input pit_div_type sel);
        pit_count_type one;
        one = 16'h0001;
        pit_div_mask = (one << sel) - one;
    endfunction : pit_div_mask

endpackage : pit_pkg
